/* shared/sfp_pkg.sv */
// Constants and types for the programmable-flag first-in first-out buffer
package sfp_pkg;

  // ****************************************************************
  // Geometry
  // ****************************************************************
  // Data word width
  localparam int unsigned DATA_W = 9;
  // Address width of the storage array
  localparam int unsigned ADDR_W = 9;
  // Width of one flag-offset register
  localparam int unsigned OFS_W  = 8;
  // Number of words, at the width of a fill count
  localparam logic [ADDR_W:0] DEPTH_CNT = 10'h200;
  // Depth widened for offset arithmetic
  localparam logic [16:0] DEPTH_WIDE = 17'h00200;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  // Default offsets: seven words from either boundary
  localparam logic [OFS_W-1:0] DEF_EMPTY_LO = 8'h07;
  localparam logic [OFS_W-1:0] DEF_EMPTY_HI = 8'h00;
  localparam logic [OFS_W-1:0] DEF_FULL_LO  = 8'h07;
  localparam logic [OFS_W-1:0] DEF_FULL_HI  = 8'h00;
  // Flag levels after reset
  localparam logic RST_FULL_N   = 1'h1;
  localparam logic RST_AFULL_N  = 1'h1;
  localparam logic RST_EMPTY_N  = 1'h0;
  localparam logic RST_AEMPTY_N = 1'h0;
  // Read data after reset
  localparam logic [DATA_W-1:0] RST_RDATA = 9'h000;

  // ****************************************************************
  // Input buffer
  // ****************************************************************
  // Entries of the write-side buffer
  localparam logic [1:0] BUF_DEPTH = 2'h2;

  // ****************************************************************
  // Offset register selector, Gray coded along the load order
  // ****************************************************************
  typedef enum logic [1:0] {
    SEL_EMPTY_LO = 2'b00,
    SEL_EMPTY_HI = 2'b01,
    SEL_FULL_LO  = 2'b11,
    SEL_FULL_HI  = 2'b10
  } sfp_sel_t;

endpackage : sfp_pkg

/* src/sfp_fifo.sv */
// Single-clock 512 x 9 first-in first-out buffer with programmable flags
`timescale 1ns/100ps
`default_nettype none

module sfp_fifo (
  // Clock and reset
  input  wire logic                       clock,
  input  wire logic                       reset_n,
  // Write side
  input  wire logic [sfp_pkg::DATA_W-1:0] write_data,
  input  wire logic                       write_enable_a_n,
  input  wire logic                       write_enable_b_or_offset_load,
  // Read side
  input  wire logic                       read_enable_a_n,
  input  wire logic                       read_enable_b_n,
  output logic      [sfp_pkg::DATA_W-1:0] read_data,
  // Status flags, all active low
  output logic                            empty_flag_n,
  output logic                            almost_empty_flag_n,
  output logic                            full_flag_n,
  output logic                            almost_full_flag_n
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic                                   load_mode;  // Pin is offset load
    logic [sfp_pkg::ADDR_W-1:0]             wr_ptr;     // Next storage slot
    logic [sfp_pkg::ADDR_W-1:0]             rd_ptr;     // Next word to read
    logic [sfp_pkg::ADDR_W:0]               total;      // Words incl. buffer
    logic [sfp_pkg::ADDR_W:0]               mem_cnt;    // Words in storage
    logic [1:0]                             buf_cnt;    // Buffer occupancy
    logic [1:0][sfp_pkg::DATA_W-1:0]        buf_word;   // Entry 0 is oldest
    sfp_pkg::sfp_sel_t                      wr_sel;     // Next offset written
    sfp_pkg::sfp_sel_t                      rd_sel;     // Next offset read
    logic [3:0][sfp_pkg::OFS_W-1:0]         ofs;        // Indexed by selector
    logic [sfp_pkg::DATA_W-1:0]             rdata;      // Output register
    logic                                   ef_n;       // Empty flag
    logic                                   ae_n;       // Almost-empty flag
    logic                                   ff_n;       // Full flag
    logic                                   af_n;       // Almost-full flag
  } sfp_state_t;

  sfp_state_t                     s;         // Registered state
  sfp_state_t                     next_s;    // Next state
  logic [sfp_pkg::DATA_W-1:0]     mem [0:sfp_pkg::DEPTH_CNT-1]; // Storage

  // Decoded strobes
  logic                           buf_ready; // Buffer can take a word
  logic                           do_push;   // Word accepted into buffer
  logic                           do_drain;  // Oldest buffered word stored
  logic                           do_read;   // Word leaves storage
  logic                           ofs_wr;    // Offset register write
  logic                           ofs_rd;    // Offset register read
  logic [1:0]                     cnt_mid;   // Occupancy after draining
  logic [15:0]                    empty_ofs; // Offset n
  logic [15:0]                    full_ofs;  // Offset m

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Step through offset registers; used by both load directions
  function automatic sfp_pkg::sfp_sel_t sfp_next_sel(
    input sfp_pkg::sfp_sel_t sel
  );
    sfp_pkg::sfp_sel_t nxt;
    nxt = sfp_pkg::SEL_EMPTY_LO;
    case (sel)
      sfp_pkg::SEL_EMPTY_LO: nxt = sfp_pkg::SEL_EMPTY_HI;
      sfp_pkg::SEL_EMPTY_HI: nxt = sfp_pkg::SEL_FULL_LO;
      sfp_pkg::SEL_FULL_LO:  nxt = sfp_pkg::SEL_FULL_HI;
      sfp_pkg::SEL_FULL_HI:  nxt = sfp_pkg::SEL_EMPTY_LO;
      default:               nxt = sfp_pkg::SEL_EMPTY_LO;
    endcase
    return nxt;
  endfunction : sfp_next_sel

  // ****************************************************************
  // Strobe decode
  // ****************************************************************
  // Buffer back-pressure stalls acceptance rather than losing a word
  assign buf_ready = (s.buf_cnt != sfp_pkg::BUF_DEPTH);
  // Pin high acts as second enable
  assign do_push   = ~write_enable_a_n & write_enable_b_or_offset_load
                     & s.ff_n & buf_ready;
  // Storage always has room, since the full flag counts the buffer too
  assign do_drain  = (s.buf_cnt != 2'h0);
  // Read condition; second enable only matters in load mode
  assign do_read   = ~read_enable_a_n & ~read_enable_b_n & s.ef_n
                     & (~s.load_mode | write_enable_b_or_offset_load);
  assign ofs_wr    = s.load_mode & ~write_enable_b_or_offset_load
                     & ~write_enable_a_n;
  assign ofs_rd    = s.load_mode & ~write_enable_b_or_offset_load
                     & ~read_enable_a_n & ~read_enable_b_n;
  assign cnt_mid   = do_drain ? s.buf_cnt - 2'h1 : s.buf_cnt;
  // Offsets as registered; the next-state logic reads its own copy
  assign empty_ofs = {s.ofs[sfp_pkg::SEL_EMPTY_HI],
                      s.ofs[sfp_pkg::SEL_EMPTY_LO]};
  assign full_ofs  = {s.ofs[sfp_pkg::SEL_FULL_HI],
                      s.ofs[sfp_pkg::SEL_FULL_LO]};

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  // Flags are derived from next counts so each is exactly one flop
  always_comb begin
    next_s = s;
    // Buffer shift out toward storage
    if (do_drain) begin
      next_s.buf_word[0] = s.buf_word[1];
      next_s.wr_ptr = s.wr_ptr + 1'b1;
    end
    // Buffer fill behind the remaining words
    if (do_push) begin
      next_s.buf_word[cnt_mid[0]] = write_data;
    end
    next_s.buf_cnt = cnt_mid + {1'b0, do_push};
    // Both sides move in the same cycle if asked
    next_s.total   = s.total + {{sfp_pkg::ADDR_W{1'b0}}, do_push}
                     - {{sfp_pkg::ADDR_W{1'b0}}, do_read};
    next_s.mem_cnt = s.mem_cnt + {{sfp_pkg::ADDR_W{1'b0}}, do_drain}
                     - {{sfp_pkg::ADDR_W{1'b0}}, do_read};
    // Output changes only on an enabled read
    if (do_read) begin
      next_s.rdata  = mem[s.rd_ptr];
      next_s.rd_ptr = s.rd_ptr + 1'b1;
    end else if (ofs_rd) begin
      // Offsets read back in load order
      next_s.rdata  = {1'b0, s.ofs[s.rd_sel]};
      next_s.rd_sel = sfp_next_sel(s.rd_sel);
    end
    // Offset registers written over the data path
    if (ofs_wr) begin
      next_s.ofs[s.wr_sel] = write_data[sfp_pkg::OFS_W-1:0];
      next_s.wr_sel = sfp_next_sel(s.wr_sel);
    end
    // Empty when nothing is in storage
    next_s.ef_n = (next_s.mem_cnt != '0);
    // Almost empty at n or fewer words
    // New offsets are used from the edge that writes them
    next_s.ae_n = ({6'h00, next_s.mem_cnt}
                   > {next_s.ofs[sfp_pkg::SEL_EMPTY_HI], next_s.ofs[sfp_pkg::SEL_EMPTY_LO]});
    // Full once depth words are held
    // Full rises at the edge of a read
    next_s.ff_n = (next_s.total != sfp_pkg::DEPTH_CNT);
    // Almost full from depth minus m
    next_s.af_n = (({7'h00, next_s.total}
                    + {1'b0, next_s.ofs[sfp_pkg::SEL_FULL_HI], next_s.ofs[sfp_pkg::SEL_FULL_LO]})
                   < sfp_pkg::DEPTH_WIDE);
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  // Mode is sampled every reset cycle; the last one before release wins
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      s           <= '0;
      // Mode chosen by the pin at release
      s.load_mode <= ~write_enable_b_or_offset_load;
      s.ofs[sfp_pkg::SEL_EMPTY_LO] <= sfp_pkg::DEF_EMPTY_LO;
      s.ofs[sfp_pkg::SEL_EMPTY_HI] <= sfp_pkg::DEF_EMPTY_HI;
      s.ofs[sfp_pkg::SEL_FULL_LO]  <= sfp_pkg::DEF_FULL_LO;
      s.ofs[sfp_pkg::SEL_FULL_HI]  <= sfp_pkg::DEF_FULL_HI;
      s.rdata     <= sfp_pkg::RST_RDATA;
      s.ef_n      <= sfp_pkg::RST_EMPTY_N;
      s.ae_n      <= sfp_pkg::RST_AEMPTY_N;
      s.ff_n      <= sfp_pkg::RST_FULL_N;
      s.af_n      <= sfp_pkg::RST_AFULL_N;
    end else begin
      s <= next_s;
    end
  end

  // Storage array; no reset, contents are only read behind the count
  always_ff @(posedge clock) begin
    if (do_drain) begin
      mem[s.wr_ptr] <= s.buf_word[0];
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Full flags straight from their flops
  assign full_flag_n         = s.ff_n;
  assign almost_full_flag_n  = s.af_n;
  // Empty flags straight from their flops
  assign empty_flag_n        = s.ef_n;
  assign almost_empty_flag_n = s.ae_n;
  assign read_data           = s.rdata;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  // Write accepted into an empty store, then nothing read
  sequence sfp_first_write;
    !s.ef_n && s.buf_cnt == 2'h0 && do_push;
  endsequence
  sequence sfp_empty_clears;
    ##2 s.ef_n;
  endsequence

  // Flags and output after a reset cycle
  a_reset_values: assert property (disable iff (1'b0)
    !reset_n |=> (s.ff_n && s.af_n && !s.ef_n && !s.ae_n
                  && read_data == '0 && s.rd_ptr == '0 && s.wr_ptr == '0))
    else $error("reset values wrong");

  a_default_offsets: assert property (disable iff (1'b0)
    !reset_n |=> (empty_ofs == 16'h0007 || !reset_n))
    else $error("default empty offset wrong");

  a_full_blocks: assert property (
    !s.ff_n && !do_read |=> s.total == $past(s.total))
    else $error("write taken while full");

  a_full_level: assert property (
    !full_flag_n == (s.total == sfp_pkg::DEPTH_CNT))
    else $error("full flag disagrees with count");

  a_empty_level: assert property (
    !empty_flag_n == (s.mem_cnt == '0))
    else $error("empty flag disagrees with count");

  a_empty_clear: assert property (
    sfp_first_write |-> sfp_empty_clears)
    else $error("empty flag slow after first write");

  a_read_hold: assert property (
    read_enable_a_n || read_enable_b_n |=> $stable(read_data))
    else $error("output changed with read disabled");

  a_read_advance: assert property (
    do_read |=> s.rd_ptr == $past(s.rd_ptr) + 1'b1
                && read_data == $past(mem[s.rd_ptr]))
    else $error("read did not advance");

  a_offset_wrap: assert property (
    ofs_wr && s.wr_sel == sfp_pkg::SEL_FULL_HI
      |=> s.wr_sel == sfp_pkg::SEL_EMPTY_LO)
    else $error("offset selector did not wrap");

  a_almost_empty: assert property (
    almost_empty_flag_n == ({6'h00, s.mem_cnt}
      > {s.ofs[sfp_pkg::SEL_EMPTY_HI], s.ofs[sfp_pkg::SEL_EMPTY_LO]}))
    else $error("almost-empty level wrong");

  a_flow_no_load: assert property (
    !s.load_mode |-> !ofs_wr && !ofs_rd)
    else $error("offset access in flow mode");

  // Flow mode never leaves the default offsets
  a_flow_defaults: assert property (
    !s.load_mode |-> full_ofs == {sfp_pkg::DEF_FULL_HI, sfp_pkg::DEF_FULL_LO}
                     && empty_ofs == {sfp_pkg::DEF_EMPTY_HI, sfp_pkg::DEF_EMPTY_LO})
    else $error("offsets moved in flow mode");

  // Mode is frozen once reset is over
  a_mode_frozen: assert property (
    reset_n |=> $stable(s.load_mode))
    else $error("mode changed outside reset");

  // Accepted write raises the count by one
  a_write_store: assert property (
    do_push && !do_read |=> s.total == $past(s.total) + 10'h001)
    else $error("write not counted");

  // A read from a full buffer frees the flag at once
  a_full_release: assert property (
    !s.ff_n && do_read |=> full_flag_n)
    else $error("full flag slow after read");

  // Read pointer frozen while empty
  a_empty_ignore: assert property (
    !s.ef_n |=> $stable(s.rd_ptr))
    else $error("read taken while empty");

  // First offset register takes the data bits
  a_offset_store: assert property (
    ofs_wr && s.wr_sel == sfp_pkg::SEL_EMPTY_LO
      |=> s.ofs[sfp_pkg::SEL_EMPTY_LO] == $past(write_data[sfp_pkg::OFS_W-1:0]))
    else $error("offset write lost");

  // Selector only moves on an offset write
  a_partial_keep: assert property (
    !ofs_wr |=> $stable(s.wr_sel))
    else $error("offset selector drifted");

  // Almost-full level against the registered count
  a_almost_full: assert property (
    almost_full_flag_n == (({7'h00, s.total} + {1'b0, full_ofs}) < sfp_pkg::DEPTH_WIDE))
    else $error("almost-full level wrong");

  // Offset read puts the selected register on the output
  a_offset_read: assert property (
    ofs_rd |=> read_data == {1'b0, $past(s.ofs[s.rd_sel])})
    else $error("offset read wrong");

  // Read pointer wraps from the last slot to the first
  a_ptr_wrap: assert property (
    do_read && s.rd_ptr == 9'h1ff |=> s.rd_ptr == 9'h000)
    else $error("read pointer did not wrap");

endmodule : sfp_fifo

`default_nettype wire

/* bench/sfp_reader.sv */
// Reading-side partner model that pulls words and hands them to the bench
`timescale 1ns/100ps
`default_nettype none

module sfp_reader (
  // Clock and reset
  input  wire logic                       clock,
  input  wire logic                       reset_n,
  // Bench control
  input  wire logic                       pull,
  input  wire logic [1:0]                 stall,
  // Device side
  input  wire logic                       empty_flag_n,
  input  wire logic [sfp_pkg::DATA_W-1:0] read_data,
  output logic                            read_enable_a_n,
  output logic                            read_enable_b_n,
  // Captured word, valid for one cycle
  output logic                            got_valid,
  output logic      [sfp_pkg::DATA_W-1:0] got
);
  logic taken;  // A word was taken at the last edge

  // Either enable may be withheld, so both stall paths get exercised
  always_comb begin
    read_enable_a_n = !(pull && !stall[0]);
    read_enable_b_n = !(pull && !stall[1]);
  end

  // count a take only while the flag is high
  always_ff @(posedge clock) begin
    taken <= reset_n && !read_enable_a_n && !read_enable_b_n && empty_flag_n;
  end

  // Capture mid-cycle, once the output register has settled
  always_ff @(negedge clock) begin
    got_valid <= taken;
    got       <= read_data;
  end
endmodule : sfp_reader
`default_nettype wire

/* bench/sfp_fifo_bench.sv */
// Self-checking bench for the programmable-flag buffer
`timescale 1ns/100ps
`default_nettype none

module sfp_fifo_bench;
  // ******************************
  // Signals
  // ******************************
  logic       clock;
  logic       reset_n;
  logic [8:0] wdata;
  logic       wen_a_n;
  logic       dual;       // Second enable or offset load
  logic       pull;       // Reader active
  logic [1:0] stall;      // Reader withholds an enable
  logic       ren_a_n;
  logic       ren_b_n;
  logic [8:0] rdata;
  logic       ef;
  logic       aef;
  logic       ff;
  logic       aff;
  logic       got_valid;
  logic [8:0] got;
  logic [8:0] held;       // Last word expected at the reader
  logic [8:0] q[$];       // Words still owed by the buffer
  logic [8:0] ofs[4] = '{9'h004, 9'h000, 9'h003, 9'h001};
  int         err_total;
  int         n_checks;
  integer     seed = 32'h5e4d9bf3;

  sfp_fifo dut_u (.clock(clock), .reset_n(reset_n), .write_data(wdata),
    .write_enable_a_n(wen_a_n), .write_enable_b_or_offset_load(dual),
    .read_enable_a_n(ren_a_n), .read_enable_b_n(ren_b_n), .read_data(rdata),
    .empty_flag_n(ef), .almost_empty_flag_n(aef), .full_flag_n(ff),
    .almost_full_flag_n(aff));

  sfp_reader rd_u (.clock(clock), .reset_n(reset_n), .pull(pull), .stall(stall),
    .empty_flag_n(ef), .read_data(rdata), .read_enable_a_n(ren_a_n),
    .read_enable_b_n(ren_b_n), .got_valid(got_valid), .got(got));

  // 100 MHz clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // ******************************
  // Tasks
  // ******************************
  task check(input logic [8:0] seen, input logic [8:0] want, input string what);
    n_checks++;
    if (seen !== want) begin
      err_total++;
      $display("[FAIL] %0t %s: saw %h want %h", $time, what, seen, want);
    end
  endtask : check

  task end_of_test;
    if (err_total == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test

  // Pin level at the last reset edge picks the mode
  task do_reset(input logic pin);
    @(negedge clock);
    reset_n = 1'b0;
    dual    = pin;
    wen_a_n = 1'b1;
    pull    = 1'b0;
    repeat (10) @(negedge clock);
    reset_n = 1'b1;
  endtask : do_reset

  task wr(input logic [8:0] d, input logic pin);
    @(negedge clock);
    wdata   = d;
    wen_a_n = 1'b0;
    dual    = pin;
  endtask : wr

  task idle(input int n);
    repeat (n) begin
      @(negedge clock);
      wen_a_n = 1'b1;
      dual    = 1'b1;
    end
  endtask : idle

  // Reader empties the buffer under random stalls
  task drain;
    int k;
    k    = 0;
    pull = 1'b1;
    while (q.size() > 0 && k < 4000) begin
      @(negedge clock);
      stall = 2'($random(seed));
      k++;
    end
    stall = 2'h0;
    repeat (4) @(negedge clock);
    check(9'(q.size()), 9'h000, "words lost");
    check(9'(ef), 9'h000, "empty after drain");
    check(rdata, held, "hold at empty");
    pull = 1'b0;
  endtask : drain

  // Words reaching the reader must arrive in write order
  always @(posedge clock) begin
    if (got_valid === 1'b1) begin
      held = (q.size() > 0) ? q.pop_front() : 9'h1ff;
      check(got, held, "read order");
    end
  end

  // Cuts a hang short
  initial begin
    repeat (20000) @(posedge clock);
    err_total++;
    end_of_test();
  end

  // ******************************
  // Main sequence
  // ******************************
  initial begin
    int i;
    err_total = 0;
    n_checks  = 0;
    reset_n   = 1'b0;
    wdata     = 9'h000;
    wen_a_n   = 1'b1;
    dual      = 1'b1;
    pull      = 1'b0;
    stall     = 2'h0;
    held      = 9'h000;
    do_reset(1'b1);
    @(negedge clock);
    check(9'({ff, aff, ef, aef}), 9'h00c, "reset flags");
    check(rdata, 9'h000, "reset output");
    pull = 1'b1;
    repeat (3) @(negedge clock);
    pull = 1'b0;
    check(rdata, 9'h000, "read on empty");
    // In flow mode a low pin blocks the write
    wr(9'h155, 1'b0);
    // Stream 512 words, then one refused write at full
    for (i = 0; i <= 512; i++) begin
      @(negedge clock);
      if (i > 0) begin
        check(9'(ff), 9'(i < 512), "full flag");
        check(9'(aff), 9'(i < 505), "almost full");
        check(9'(ef), 9'(i > 1), "empty flag");
        check(9'(aef), 9'(i > 8), "almost empty");
      end
      wdata   = 9'($random(seed));
      wen_a_n = 1'b0;
      dual    = 1'b1;
      if (i < 512) q.push_back(wdata);
    end
    idle(2);
    check(9'(ff), 9'h000, "full holds");
    pull = 1'b1;
    repeat (2) @(negedge clock);
    check(9'(ff), 9'h001, "full release");
    drain();
    // Three more words, after both pointers have wrapped to slot 0
    for (i = 0; i < 3; i++) begin
      wr(9'($random(seed)), 1'b1);
      q.push_back(wdata);
    end
    idle(1);
    drain();
    // Load mode: partial load, resume, then wrap to the first register
    do_reset(1'b0);
    wr(9'h005, 1'b0);
    wr(9'h000, 1'b0);
    idle(1);
    wr(9'h003, 1'b0);
    wr(9'h001, 1'b0);
    wr(9'h004, 1'b0);
    idle(1);
    dual = 1'b0;
    pull = 1'b1;
    for (i = 0; i < 4; i++) begin
      @(negedge clock);
      check(rdata, ofs[i], "offset read");
    end
    dual = 1'b1;
    pull = 1'b0;
    for (i = 0; i < 5; i++) begin
      wr(9'h100 + 9'(i), 1'b1);
      q.push_back(wdata);
    end
    idle(4);
    check(9'(aef), 9'h001, "above offset");
    pull  = 1'b1;
    stall = 2'b01;
    repeat (2) @(negedge clock);
    check(rdata, 9'h001, "hold first");
    stall = 2'b10;
    repeat (2) @(negedge clock);
    check(rdata, 9'h001, "hold second");
    stall = 2'b00;
    @(negedge clock);
    pull = 1'b0;
    repeat (3) @(negedge clock);
    check(9'(aef), 9'h000, "at offset");
    drain();
    end_of_test();
  end
endmodule : sfp_fifo_bench
`default_nettype wire
